// >>> src/ppc_pkg.sv
// constants for the port pad configuration register bank
package ppc_pkg;
	// ************************************************
	// register byte addresses
	// ************************************************
	localparam logic [15:0] PPC_ADDR_P0L_DRV = 16'hF080;
	localparam logic [15:0] PPC_ADDR_P0H_DRV = 16'hF082;
	localparam logic [15:0] PPC_ADDR_P1L_DRV = 16'hF084;
	localparam logic [15:0] PPC_ADDR_P1H_DRV = 16'hF086;
	localparam logic [15:0] PPC_ADDR_P2_DRV = 16'hF088;
	localparam logic [15:0] PPC_ADDR_P3_DRV = 16'hF08A;
	localparam logic [15:0] PPC_ADDR_P4_DRV = 16'hF08C;
	localparam logic [15:0] PPC_ADDR_P6_DRV = 16'hF08E;
	localparam logic [15:0] PPC_ADDR_P7_DRV = 16'hF090;
	localparam logic [15:0] PPC_ADDR_P8_DRV = 16'hF092;
	localparam logic [15:0] PPC_ADDR_THRESH = 16'hF1C4;
	// open-drain registers, extended space
	localparam logic [15:0] PPC_ADDR_OD2 = 16'hF1C6;
	localparam logic [15:0] PPC_ADDR_OD3 = 16'hF1C8;
	localparam logic [15:0] PPC_ADDR_OD4 = 16'hF1CA;
	localparam logic [15:0] PPC_ADDR_OD6 = 16'hF1CC;
	localparam logic [15:0] PPC_ADDR_OD7 = 16'hF1CE;
	localparam logic [15:0] PPC_ADDR_OD8 = 16'hF1D0;
	// ************************************************
	// reset values and implemented-bit masks
	// ************************************************
	localparam logic [15:0] PPC_RST_16 = 16'h0000;
	localparam logic [7:0] PPC_RST_8 = 8'h00;
	localparam logic [7:0] PPC_THRESH_MASK = 8'hDF;
	localparam logic [15:0] PPC_OD3_MASK = 16'hBFFF;
	localparam logic [15:0] PPC_DRV3_MASK = 16'hFFFF;
	// ************************************************
	// field codes
	// ************************************************
	localparam logic [1:0] PPC_EDGE_FAST = 2'h0;
	localparam logic [1:0] PPC_EDGE_SLOW = 2'h1;
	localparam logic [1:0] PPC_DRV_MAX = 2'h0;
	localparam logic [1:0] PPC_DRV_DYN = 2'h1;
	localparam logic [1:0] PPC_DRV_LOW = 2'h2;
	localparam int PPC_SLOW_EDGE_NS = 60;
endpackage

// >>> src/ppc_regs.sv
// port pad configuration register bank
// Notes on behaviour
// - bit 0 push-pull, 1 open drain
// - open-drain registers only ports 2,3,4,6,7,8
// - open-drain registers in extended space
// - threshold per byte of each port
// - threshold bits order, reset zero
// - threshold never touches direction or mode
// - nibble n: edge 4n+1:4n, drive 4n+3:4n+2
// - edge 00 fast, 01 slow ~60 ns
// - drive 00 max, 01 dynamic, 10 reduced
// - 8-bit registers read zero above bit 7
// - ten drive registers F080h..F092h
`timescale 1ns/1ps
module ppc_regs
	import ppc_pkg::*;
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// register port
	input wire logic [15:0] i_addr,
	input wire logic [15:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [15:0] o_rdata,
	// pad drive controls: edge/drive per nibble
	output logic [7:0] o_p0l_drive,
	output logic [7:0] o_p0h_drive,
	output logic [7:0] o_p1l_drive,
	output logic [7:0] o_p1h_drive,
	output logic [15:0] o_p2_drive,
	output logic [15:0] o_p3_drive,
	output logic [7:0] o_p4_drive,
	output logic [7:0] o_p6_drive,
	output logic [7:0] o_p7_drive,
	output logic [7:0] o_p8_drive,
	// input threshold selection
	output logic [7:0] o_threshold,
	// open-drain per line
	output logic [15:0] o_od2,
	output logic [15:0] o_od3,
	output logic [7:0] o_od4,
	output logic [7:0] o_od6,
	output logic [7:0] o_od7,
	output logic [7:0] o_od8
);
	// ************************************************
	// state
	// ************************************************
	logic [7:0] d8_r [8];
	logic [7:0] d8_nxt [8];
	logic [15:0] p2d_r, p2d_nxt, p3d_r, p3d_nxt;
	logic [7:0] thr_r, thr_nxt;
	logic [15:0] od2_r, od2_nxt, od3_r, od3_nxt;
	logic [7:0] od8b_r [4];
	logic [7:0] od8b_nxt [4];
	logic [15:0] rdata_r, rdata_nxt;

	// index of 8-bit drive registers: p0l p0h p1l p1h p4 p6 p7 p8
	function automatic int drv8_index(input logic [15:0] a);
		case (a)
			PPC_ADDR_P0L_DRV: drv8_index = 0;
			PPC_ADDR_P0H_DRV: drv8_index = 1;
			PPC_ADDR_P1L_DRV: drv8_index = 2;
			PPC_ADDR_P1H_DRV: drv8_index = 3;
			PPC_ADDR_P4_DRV: drv8_index = 4;
			PPC_ADDR_P6_DRV: drv8_index = 5;
			PPC_ADDR_P7_DRV: drv8_index = 6;
			PPC_ADDR_P8_DRV: drv8_index = 7;
			default: drv8_index = -1;
		endcase
	endfunction

	// index of 8-bit open-drain registers: p4 p6 p7 p8
	function automatic int od8_index(input logic [15:0] a);
		case (a)
			PPC_ADDR_OD4: od8_index = 0;
			PPC_ADDR_OD6: od8_index = 1;
			PPC_ADDR_OD7: od8_index = 2;
			PPC_ADDR_OD8: od8_index = 3;
			default: od8_index = -1;
		endcase
	endfunction

	// ************************************************
	// write decode and read mux
	// ************************************************
	// fields are stored raw; reserved codes are passed to the pad as written
	always_comb
	begin
		int di;
		int oi;
		di = drv8_index(i_addr);
		oi = od8_index(i_addr);
		d8_nxt = d8_r;
		od8b_nxt = od8b_r;
		p2d_nxt = p2d_r;
		p3d_nxt = p3d_r;
		thr_nxt = thr_r;
		od2_nxt = od2_r;
		od3_nxt = od3_r;
		rdata_nxt = 16'h0000;
		if (i_wr && di >= 0)
			d8_nxt[di] = i_wdata[7:0];
		if (i_wr && i_addr == PPC_ADDR_P2_DRV)
			p2d_nxt = i_wdata;
		if (i_wr && i_addr == PPC_ADDR_P3_DRV)
			p3d_nxt = i_wdata & PPC_DRV3_MASK;
		if (i_wr && i_addr == PPC_ADDR_THRESH)
			thr_nxt = i_wdata[7:0] & PPC_THRESH_MASK;
		if (i_wr && i_addr == PPC_ADDR_OD2)
			od2_nxt = i_wdata;
		if (i_wr && i_addr == PPC_ADDR_OD3)
			od3_nxt = i_wdata & PPC_OD3_MASK;
		if (i_wr && oi >= 0)
			od8b_nxt[oi] = i_wdata[7:0];
		// 8-bit registers read high byte zero
		if (i_rd)
		begin
			if (di >= 0)
				rdata_nxt = {8'h00, d8_r[di]};
			else if (oi >= 0)
				rdata_nxt = {8'h00, od8b_r[oi]};
			else
			begin
				case (i_addr)
					PPC_ADDR_P2_DRV: rdata_nxt = p2d_r;
					PPC_ADDR_P3_DRV: rdata_nxt = p3d_r;
					PPC_ADDR_THRESH: rdata_nxt = {8'h00, thr_r};
					PPC_ADDR_OD2: rdata_nxt = od2_r;
					PPC_ADDR_OD3: rdata_nxt = od3_r;
					default: rdata_nxt = 16'h0000; // unmapped reads zero
				endcase
			end
		end
	end

	// ************************************************
	// registers
	// ************************************************
	// registered static pad controls
	always_ff @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
		begin
			for (int k = 0; k < 8; k++)
				d8_r[k] <= PPC_RST_8;
			for (int k = 0; k < 4; k++)
				od8b_r[k] <= PPC_RST_8;
			p2d_r <= PPC_RST_16;
			p3d_r <= PPC_RST_16;
			thr_r <= PPC_RST_8;
			od2_r <= PPC_RST_16;
			od3_r <= PPC_RST_16;
			rdata_r <= PPC_RST_16;
		end
		else
		begin
			d8_r <= d8_nxt;
			od8b_r <= od8b_nxt;
			p2d_r <= p2d_nxt;
			p3d_r <= p3d_nxt;
			thr_r <= thr_nxt;
			od2_r <= od2_nxt;
			od3_r <= od3_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	// edge codes reach pads raw
	// nibble fields pass straight to pads
	assign o_p0l_drive = d8_r[0];
	assign o_p0h_drive = d8_r[1];
	assign o_p1l_drive = d8_r[2];
	assign o_p1h_drive = d8_r[3];
	assign o_p2_drive = p2d_r;
	assign o_p3_drive = p3d_r;
	assign o_p4_drive = d8_r[4];
	assign o_p6_drive = d8_r[5];
	assign o_p7_drive = d8_r[6];
	assign o_p8_drive = d8_r[7];
	// threshold is a separate output only
	assign o_threshold = thr_r;
	// open-drain bit per line, 1 = open drain
	assign o_od2 = od2_r;
	assign o_od3 = od3_r;
	assign o_od4 = od8b_r[0];
	assign o_od6 = od8b_r[1];
	assign o_od7 = od8b_r[2];
	assign o_od8 = od8b_r[3];
	assign o_rdata = rdata_r;

	// ************************************************
	// checks
	// ************************************************
	sequence s_wr_thr;
		i_wr && i_addr == PPC_ADDR_THRESH;
	endsequence

	property p_od_reset;
		@(posedge i_mclk) $rose(!i_reset) |-> o_od2 == 16'h0000 && o_od8 == 8'h00;
	endproperty
	a_od_reset: assert property (p_od_reset) else $error("open-drain not zero after reset");

	property p_od2_write;
		@(posedge i_mclk) disable iff (i_reset)
			i_wr && i_addr == PPC_ADDR_OD2 |=> o_od2 == $past(i_wdata);
	endproperty
	a_od2_write: assert property (p_od2_write) else $error("od2 write lost");

	property p_od3_hole;
		@(posedge i_mclk) disable iff (i_reset) o_od3[14] == 1'b0;
	endproperty
	a_od3_hole: assert property (p_od3_hole) else $error("od3 line 14 set");

	property p_od_extended_special_reg_space_read;
		@(posedge i_mclk) disable iff (i_reset)
			i_rd && i_addr == PPC_ADDR_OD7 |=> o_rdata == {8'h00, o_od7};
	endproperty
	a_od_extended_special_reg_space_read: assert property (p_od_extended_special_reg_space_read) else $error("od7 read wrong");

	property p_thr_write;
		@(posedge i_mclk) disable iff (i_reset)
			s_wr_thr |=> o_threshold == ($past(i_wdata[7:0]) & PPC_THRESH_MASK);
	endproperty
	a_thr_write: assert property (p_thr_write) else $error("threshold write wrong");

	property p_thr_hold;
		@(posedge i_mclk) disable iff (i_reset)
			!(i_wr && i_addr == PPC_ADDR_THRESH)
			|=> $stable(o_threshold);
	endproperty
	a_thr_hold: assert property (p_thr_hold) else $error("threshold changed");

	property p_thr_bytes;
		@(posedge i_mclk) disable iff (i_reset)
			s_wr_thr |=> o_threshold[3:0] == $past(i_wdata[3:0]) && o_threshold[5] == 1'b0;
	endproperty
	a_thr_bytes: assert property (p_thr_bytes) else $error("threshold byte bits wrong");

	property p_thr_indep;
		@(posedge i_mclk) disable iff (i_reset)
			s_wr_thr |=> $stable(o_od2) && $stable(o_p2_drive);
	endproperty
	a_thr_indep: assert property (p_thr_indep) else $error("threshold disturbed mode");

	property p_drv8_read;
		@(posedge i_mclk) disable iff (i_reset)
			i_rd && i_addr == PPC_ADDR_P4_DRV |=> o_rdata[15:8] == 8'h00
			&& o_rdata[7:0] == o_p4_drive;
	endproperty
	a_drv8_read: assert property (p_drv8_read) else $error("8-bit read high byte");

	property p_drv_write;
		@(posedge i_mclk) disable iff (i_reset)
			i_wr && i_addr == PPC_ADDR_P8_DRV |=> o_p8_drive == $past(i_wdata[7:0]);
	endproperty
	a_drv_write: assert property (p_drv_write) else $error("p8 drive write lost");

	property p_drv_nibble;
		@(posedge i_mclk) disable iff (i_reset)
			i_wr && i_addr == PPC_ADDR_P2_DRV |=> o_p2_drive[15:14] == $past(i_wdata[15:14])
			&& o_p2_drive[13:12] == $past(i_wdata[13:12]);
	endproperty
	a_drv_nibble: assert property (p_drv_nibble) else $error("nibble fields wrong");

	property p_static;
		@(posedge i_mclk) disable iff (i_reset) !i_wr |=> $stable(o_p3_drive) && $stable(o_od4);
	endproperty
	a_static: assert property (p_static) else $error("output moved with no write");

	property p_unmapped;
		@(posedge i_mclk) disable iff (i_reset) i_rd && i_addr == 16'h0000 |=> o_rdata == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");

	property p_edge_code;
		@(posedge i_mclk) disable iff (i_reset)
			i_wr && i_addr == PPC_ADDR_P2_DRV && i_wdata[1:0] == PPC_EDGE_SLOW
			|=> o_p2_drive[1:0] == PPC_EDGE_SLOW;
	endproperty
	a_edge_code: assert property (p_edge_code) else $error("slow edge code lost");

	property p_drv_code;
		@(posedge i_mclk) disable iff (i_reset)
			i_wr && i_addr == PPC_ADDR_P2_DRV && i_wdata[15:14] == PPC_DRV_LOW
			|=> o_p2_drive[15:14] == PPC_DRV_LOW;
	endproperty
	a_drv_code: assert property (p_drv_code) else $error("reduced drive code lost");

	property p_idle_rd;
		@(posedge i_mclk) disable iff (i_reset) !i_rd |=> o_rdata == 16'h0000;
	endproperty
	a_idle_rd: assert property (p_idle_rd) else $error("read data without strobe");
endmodule

// >>> verification/tb_port_pad_config_regs.sv
// self-checking bench for the port pad configuration register bank
`timescale 1ns/1ps
module tb_port_pad_config_regs;
	import ppc_pkg::*;
	// ************************************************
	// stimulus, tables and counters
	// ************************************************
	logic i_mclk = 1'b0;
	logic i_reset = 1'b1;
	logic [15:0] i_addr = 16'h0000;
	logic [15:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [15:0] o_rdata;
	logic [7:0] d0l, d0h, d1l, d1h, d4, d6, d7, d8, th, od4, od6, od7, od8;
	logic [15:0] d2, d3, od2, od3, rv;
	int miscompares = 0;
	int samples_checked = 0;
	localparam logic [15:0] ADDRS [17] = '{PPC_ADDR_P0L_DRV, PPC_ADDR_P0H_DRV,
		PPC_ADDR_P1L_DRV, PPC_ADDR_P1H_DRV, PPC_ADDR_P2_DRV, PPC_ADDR_P3_DRV,
		PPC_ADDR_P4_DRV, PPC_ADDR_P6_DRV, PPC_ADDR_P7_DRV, PPC_ADDR_P8_DRV,
		PPC_ADDR_THRESH, PPC_ADDR_OD2, PPC_ADDR_OD3, PPC_ADDR_OD4, PPC_ADDR_OD6,
		PPC_ADDR_OD7, PPC_ADDR_OD8};
	// writable bits per register; 8-bit ones drop their high byte
	localparam logic [15:0] MASKS [17] = '{16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF,
		16'hFFFF, 16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00DF,
		16'hFFFF, 16'hBFFF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF};
	logic [15:0] exp_r [17] = '{default: 16'h0000};

	// clock of 25 ns period
	always #12.5 i_mclk = ~i_mclk;

	ppc_regs dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_p0l_drive(d0l), .o_p0h_drive(d0h),
		.o_p1l_drive(d1l), .o_p1h_drive(d1h), .o_p2_drive(d2), .o_p3_drive(d3),
		.o_p4_drive(d4), .o_p6_drive(d6), .o_p7_drive(d7), .o_p8_drive(d8),
		.o_threshold(th), .o_od2(od2), .o_od3(od3), .o_od4(od4), .o_od6(od6),
		.o_od7(od7), .o_od8(od8));

	// ************************************************
	// access tasks and checks
	// ************************************************
	// pad output that belongs to register index i
	function automatic logic [15:0] pad_out(input int i);
		case (i)
			0: return {8'h00, d0l};
			1: return {8'h00, d0h};
			2: return {8'h00, d1l};
			3: return {8'h00, d1h};
			4: return d2;
			5: return d3;
			6: return {8'h00, d4};
			7: return {8'h00, d6};
			8: return {8'h00, d7};
			9: return {8'h00, d8};
			10: return {8'h00, th};
			11: return od2;
			12: return od3;
			13: return {8'h00, od4};
			14: return {8'h00, od6};
			15: return {8'h00, od7};
			default: return {8'h00, od8};
		endcase
	endfunction

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one-cycle write strobe, then released
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		// step off the edge so callers see the value the write launched
		#1;
	endtask

	// read data is only valid in the cycle after the strobe
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge i_mclk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 d = o_rdata;
	endtask

	task automatic wr_idx(input int i, input logic [15:0] d);
		wr(ADDRS[i], d);
		exp_r[i] = d & MASKS[i];
	endtask

	// read back every register and compare its pad outputs too
	task automatic chk_all();
		for (int i = 0; i < 17; i++)
		begin
			rd(ADDRS[i], rv);
			chk($sformatf("rdata%0d", i), rv, exp_r[i]);
			chk($sformatf("pad%0d", i), pad_out(i), exp_r[i]);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// ************************************************
	// test sequence
	// ************************************************
	initial
	begin
		repeat (20) @(posedge i_mclk);
		i_reset <= 1'b0;
		// all registers clear after reset
		chk_all();
		// distinct patterns catch address aliasing and masked bits
		for (int i = 0; i < 17; i++)
			wr_idx(i, 16'hFFFF ^ (16'h0101 * 16'(i)));
		chk_all();
		// every edge and drive code in every nibble of the P2 drive register
		for (int c = 0; c < 16; c++)
		begin
			wr_idx(4, 16'h1111 * 16'(c));
			for (int n = 0; n < 4; n++)
			begin
				chk("edge", {14'h0000, d2[4*n +: 2]}, 16'(c % 4));
				chk("drive", {14'h0000, d2[4*n+2 +: 2]}, 16'(c / 4));
			end
		end
		// threshold change leaves open-drain and drive settings alone
		wr_idx(10, 16'h0000);
		chk("od2", od2, exp_r[11]);
		chk("p2", d2, exp_r[4]);
		// back-to-back write then read, and read data returns to zero
		@(posedge i_mclk);
		i_wr <= 1'b1;
		i_addr <= PPC_ADDR_P7_DRV;
		i_wdata <= 16'hAB5A;
		@(posedge i_mclk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1 chk("b2b", o_rdata, 16'h005A);
		@(posedge i_mclk);
		#1 chk("rd_idle", o_rdata, 16'h0000);
		exp_r[8] = 16'h005A;
		// unmapped address: write ignored, read gives zero
		wr(16'hF1D2, 16'hFFFF);
		rd(16'hF1D2, rv);
		chk("unmapped", rv, 16'h0000);
		chk_all();
		// reset in mid-run clears everything
		@(posedge i_mclk);
		i_reset <= 1'b1;
		@(posedge i_mclk);
		i_reset <= 1'b0;
		exp_r = '{default: 16'h0000};
		chk_all();
		give_verdict();
	end

	// watchdog cuts a hang short
	initial
	begin
		repeat (4000) @(posedge i_mclk);
		miscompares++;
		give_verdict();
	end
endmodule
